// >>> common/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// ****************************************
// register bus byte addresses
// ****************************************
`define CRS_A_PSW 8'h40
`define CRS_A_PBASE 8'h44
`define CRS_A_VBASE 8'h48
`define CRS_A_MACH 8'h4C
`define CRS_A_MACL 8'h50
`define CRS_A_PR 8'h54
`define CRS_A_PC 8'h58
`define CRS_GP_REGION 2'h0
`define CRS_WORD_ALIGN 2'h0
// ****************************************
// core-side selector codes
// ****************************************
`define CRS_SYS_PSW 3'h0
`define CRS_SYS_PBASE 3'h1
`define CRS_SYS_VBASE 3'h2
`define CRS_SYS_MACH 3'h3
`define CRS_SYS_MACL 3'h4
`define CRS_SYS_PR 3'h5
`define CRS_SYS_PC 3'h6
`define CRS_SP_IDX 4'hF
`define CRS_IDX_IDX 4'h0
// ****************************************
// status word fields and values
// ****************************************
`define CRS_PSW_T 0
`define CRS_PSW_S 1
`define CRS_PSW_MSK_LO 4
`define CRS_PSW_MSK_HI 7
`define CRS_PSW_Q 8
`define CRS_PSW_M 9
`define CRS_PSW_WMASK 32'h000003F3
`define CRS_PSW_RST 32'h000000F0
`define CRS_MSK_ALL 4'hF
`define CRS_VBASE_RST 32'h00000000
`define CRS_WORD_BYTES 32'h00000004
`define CRS_ZERO 32'h00000000
`endif

// >>> common/crs_pkg.sv
package crs_pkg;
  typedef enum logic [6:0] {
    CRS_IDLE = 7'h01,
    CRS_PUSH_PSW = 7'h02,
    CRS_PUSH_PC = 7'h04,
    CRS_POP_PC = 7'h08,
    CRS_POP_PSW = 7'h10,
    CRS_LD_PC = 7'h20,
    CRS_LD_PSW = 7'h40
  } crs_state_e;
endpackage

// >>> verification/crs_cpu_register_set_tb.sv
`timescale 1ns/100ps
`include "crs_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module crs_cpu_register_set_tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic ref_clk_i, srst_i, wr_i, rd_i, gp_wr_i, sys_wr_i;
  logic [7:0] addr_i, disp_i, vec_num_i;
  logic [31:0] wdata_i, gp_wr_data_i, sys_wr_data_i, stk_rdata_i;
  logic [3:0] gp_wr_sel_i, gp_rd_a_sel_i, gp_rd_b_sel_i;
  logic [2:0] sys_wr_sel_i;
  logic [1:0] disp_sz_i;
  logic cond_we_i, cond_i, div_we_i, div_q_i, div_m_i, exc_entry_i, exc_return_i;
  logic [31:0] rdata_o, gp_rd_a_o, gp_rd_b_o, idx_addr_o, sp_o, psw_o, pc_o;
  logic [31:0] periph_addr_o, vec_addr_o, stk_addr_o, stk_wdata_o;
  logic stk_we_o, stk_re_o, stk_busy_o;
  int n_mismatch, samples_checked;

  crs_cpu_register_set crs_cpu_register_set_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gp_wr_i(gp_wr_i),
    .gp_wr_sel_i(gp_wr_sel_i), .gp_wr_data_i(gp_wr_data_i), .gp_rd_a_sel_i(gp_rd_a_sel_i),
    .gp_rd_b_sel_i(gp_rd_b_sel_i), .gp_rd_a_o(gp_rd_a_o), .gp_rd_b_o(gp_rd_b_o),
    .idx_addr_o(idx_addr_o), .sp_o(sp_o), .sys_wr_i(sys_wr_i), .sys_wr_sel_i(sys_wr_sel_i),
    .sys_wr_data_i(sys_wr_data_i), .psw_o(psw_o), .pc_o(pc_o), .cond_we_i(cond_we_i),
    .cond_i(cond_i), .div_we_i(div_we_i), .div_q_i(div_q_i), .div_m_i(div_m_i),
    .disp_i(disp_i), .disp_sz_i(disp_sz_i), .periph_addr_o(periph_addr_o),
    .vec_num_i(vec_num_i), .vec_addr_o(vec_addr_o), .exc_entry_i(exc_entry_i),
    .exc_return_i(exc_return_i), .stk_rdata_i(stk_rdata_i), .stk_addr_o(stk_addr_o),
    .stk_wdata_o(stk_wdata_o), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o),
    .stk_busy_o(stk_busy_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(rdata_o, e)
    @(negedge ref_clk_i);
    `CHK(rdata_o, 32'h00000000)
  endtask

  task automatic core_wr(input logic sys, input logic [3:0] sel, input logic [31:0] d);
    @(posedge ref_clk_i);
    gp_wr_sel_i <= sel;
    gp_wr_data_i <= d;
    sys_wr_sel_i <= sel[2:0];
    sys_wr_data_i <= d;
    gp_wr_i <= ~sys;
    sys_wr_i <= sys;
    @(posedge ref_clk_i);
    gp_wr_i <= 1'b0;
    sys_wr_i <= 1'b0;
  endtask

  // write then read on the very next edge
  task automatic bus_wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(rdata_o, e)
  endtask

  // one edge to take the inputs, then look mid-cycle
  task automatic settle();
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {srst_i, wr_i, rd_i, gp_wr_i, sys_wr_i, cond_we_i, cond_i} = 7'h41;
    {div_we_i, div_q_i, div_m_i, exc_entry_i, exc_return_i} = 5'h00;
    {addr_i, disp_i, vec_num_i, disp_sz_i} = 26'h0000000;
    {wdata_i, gp_wr_data_i, sys_wr_data_i} = 96'h0;
    {gp_wr_sel_i, gp_rd_a_sel_i, gp_rd_b_sel_i, sys_wr_sel_i} = 15'h0000;
    stk_rdata_i = 32'h5555AAAA;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(psw_o, 32'h000000F0)
    bus_rd(`CRS_A_PSW, 32'h000000F0);
    bus_rd(`CRS_A_VBASE, 32'h00000000);
    $display("test reset done");
    bus_wr(`CRS_A_PSW, 32'hFFFFFFFF);
    bus_rd(`CRS_A_PSW, 32'h000003F3);
    bus_wr(`CRS_A_PSW, 32'hFFFFFC0C);
    bus_rd(`CRS_A_PSW, 32'h00000000);
    bus_wr(`CRS_A_PSW, 32'h000000A5);
    bus_rd(`CRS_A_PSW, 32'h000000A1);
    $display("test status fields done");
    for (int i = 0; i < 16; i++) bus_wr(8'(i * 4), 32'hA5000000 | 32'(i));
    for (int i = 0; i < 16; i++) bus_rd(8'(i * 4), 32'hA5000000 | 32'(i));
    for (int i = 1; i < 7; i++) bus_wr(8'(8'h40 + i * 4), 32'h5A000000 | 32'(i));
    for (int i = 1; i < 7; i++) bus_rd(8'(8'h40 + i * 4), 32'h5A000000 | 32'(i));
    for (int i = 3; i < 6; i++) core_wr(1'b1, 4'(i), 32'h3C000000 | 32'(i));
    for (int i = 3; i < 6; i++) bus_rd(8'(8'h40 + i * 4), 32'h3C000000 | 32'(i));
    bus_wr_rd(`CRS_A_PSW, 32'hFFFFFF12, 32'h00000312);
    bus_wr(8'h5C, 32'hFFFFFFFF);
    bus_rd(8'h5C, 32'h00000000);
    bus_rd(8'h41, 32'h00000000);
    $display("test register map done");
    core_wr(1'b0, 4'h0, 32'h00001000);
    core_wr(1'b0, 4'h3, 32'h00000024);
    core_wr(1'b0, 4'hF, 32'h00000100);
    @(posedge ref_clk_i);
    gp_rd_a_sel_i <= 4'h3;
    gp_rd_b_sel_i <= 4'hF;
    settle();
    `CHK(gp_rd_a_o, 32'h00000024)
    `CHK(gp_rd_b_o, 32'h00000100)
    `CHK(idx_addr_o, 32'h00001024)
    `CHK(sp_o, 32'h00000100)
    $display("test core ports done");
    core_wr(1'b1, 4'h1, 32'h00010000);
    core_wr(1'b1, 4'h2, 32'h00000400);
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk_i);
      disp_i <= 8'h81;
      disp_sz_i <= 2'(s);
      vec_num_i <= 8'(8'hFF - s);
      settle();
      `CHK(periph_addr_o, 32'h00010000 + (32'h81 << s))
      `CHK(vec_addr_o, 32'h00000400 + 32'((8'hFF - s) * 4))
    end
    $display("test address generation done");
    core_wr(1'b1, 4'h0, 32'h000000F0);
    @(posedge ref_clk_i);
    {cond_we_i, cond_i, div_we_i, div_q_i, div_m_i} <= 5'h1E;
    @(posedge ref_clk_i);
    {cond_i, div_q_i, div_m_i} <= 3'h1;
    @(negedge ref_clk_i);
    `CHK(psw_o, 32'h000001F1)
    @(posedge ref_clk_i);
    {cond_we_i, div_we_i} <= 2'h0;
    @(negedge ref_clk_i);
    `CHK(psw_o, 32'h000002F0)
    bus_rd(`CRS_A_PSW, 32'h000002F0);
    $display("test flags done");
    core_wr(1'b1, 4'h6, 32'h12345678);
    @(posedge ref_clk_i);
    exc_entry_i <= 1'b1;
    @(posedge ref_clk_i);
    exc_entry_i <= 1'b0;
    exc_return_i <= 1'b1;
    @(negedge ref_clk_i);
    `CHK(stk_busy_o, 1'b1)
    @(posedge ref_clk_i);
    exc_return_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({stk_we_o, stk_addr_o, stk_wdata_o}, {1'b1, 32'h000000FC, 32'h000002F0})
    @(negedge ref_clk_i);
    `CHK({stk_we_o, stk_addr_o, stk_wdata_o}, {1'b1, 32'h000000F8, 32'h12345678})
    @(negedge ref_clk_i);
    `CHK({sp_o, stk_re_o, stk_busy_o}, {32'h000000F8, 2'b00})
    @(posedge ref_clk_i);
    exc_return_i <= 1'b1;
    @(posedge ref_clk_i);
    exc_return_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(stk_busy_o, 1'b1)
    @(negedge ref_clk_i);
    `CHK({stk_re_o, stk_addr_o}, {1'b1, 32'h000000F8})
    @(posedge ref_clk_i);
    stk_rdata_i <= 32'h00002000;
    @(negedge ref_clk_i);
    `CHK({stk_re_o, stk_addr_o}, {1'b1, 32'h000000FC})
    @(posedge ref_clk_i);
    stk_rdata_i <= 32'hFFFFFF3E;
    @(negedge ref_clk_i);
    `CHK(pc_o, 32'h00002000)
    @(posedge ref_clk_i);
    stk_rdata_i <= 32'h000000C1;
    @(negedge ref_clk_i);
    `CHK({psw_o, sp_o, stk_busy_o}, {32'h00000332, 32'h00000100, 1'b0})
    $display("test exception stack done");
    wrap_up();
  end
endmodule

// >>> verilog/crs_cpu_register_set.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "crs_defines.svh"
// Summary of operation
// - sixteen general, three control, four system registers, all 32 bits wide.
// - general register zero doubles as index register for indexed addressing.
// - register fifteen is stack pointer; exceptions push and pop status and pc.
// - peripheral base plus displacement forms peripheral register addresses.
// - vector table base plus vector offset forms handler fetch address.
// - status bits 31..10, 3 and 2 are reserved and read zero.
// - status bits 9 and 8 are divide-step flags, read and write.
// - status bit 1 is the saturation flag for multiply-accumulate, read and write.
// - status bit 0 holds compare and test outcomes; branches decide on it.
// - the same bit captures carry, borrow, overflow and underflow results.
// - status bits 7..4 form a writable four-bit interrupt level mask.
// - reset sets the interrupt level mask to all ones.
module crs_cpu_register_set (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // register bus
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // general register ports
  input wire logic gp_wr_i,
  input wire logic [3:0] gp_wr_sel_i,
  input wire logic [31:0] gp_wr_data_i,
  input wire logic [3:0] gp_rd_a_sel_i,
  input wire logic [3:0] gp_rd_b_sel_i,
  output logic [31:0] gp_rd_a_o,
  output logic [31:0] gp_rd_b_o,
  output logic [31:0] idx_addr_o,
  output logic [31:0] sp_o,
  // control and system register port
  input wire logic sys_wr_i,
  input wire logic [2:0] sys_wr_sel_i,
  input wire logic [31:0] sys_wr_data_i,
  output logic [31:0] psw_o,
  output logic [31:0] pc_o,
  // flag updates from execution
  input wire logic cond_we_i,
  input wire logic cond_i,
  input wire logic div_we_i,
  input wire logic div_q_i,
  input wire logic div_m_i,
  // address generation
  input wire logic [7:0] disp_i,
  input wire logic [1:0] disp_sz_i,
  output logic [31:0] periph_addr_o,
  input wire logic [7:0] vec_num_i,
  output logic [31:0] vec_addr_o,
  // exception stack traffic
  input wire logic exc_entry_i,
  input wire logic exc_return_i,
  input wire logic [31:0] stk_rdata_i,
  output logic [31:0] stk_addr_o,
  output logic [31:0] stk_wdata_o,
  output logic stk_we_o,
  output logic stk_re_o,
  output logic stk_busy_o
);

  // ****************************************
  // storage
  // ****************************************
  logic [31:0] gp [16];
  logic [31:0] psw;
  logic [31:0] pbase;
  logic [31:0] vbase;
  logic [31:0] mach;
  logic [31:0] macl;
  logic [31:0] pr;
  logic [31:0] pc;
  crs_pkg::crs_state_e state;
  crs_pkg::crs_state_e next_state;

  // reserved status bits forced to zero
  function automatic logic [31:0] psw_clean(input logic [31:0] v);
    psw_clean = v & `CRS_PSW_WMASK;
  endfunction

  function automatic logic sys_hit(input logic we, input logic [2:0] sel,
                                   input logic [2:0] code);
    sys_hit = we && (sel == code);
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  wire bus_gp = (addr_i[7:6] == `CRS_GP_REGION) && (addr_i[1:0] == `CRS_WORD_ALIGN);
  wire [3:0] bus_gp_idx = addr_i[5:2];
  wire bus_gp_we = wr_i && bus_gp;
  wire bus_psw_we = wr_i && (addr_i == `CRS_A_PSW);
  wire bus_pbase_we = wr_i && (addr_i == `CRS_A_PBASE);
  wire bus_vbase_we = wr_i && (addr_i == `CRS_A_VBASE);
  wire bus_mach_we = wr_i && (addr_i == `CRS_A_MACH);
  wire bus_macl_we = wr_i && (addr_i == `CRS_A_MACL);
  wire bus_pr_we = wr_i && (addr_i == `CRS_A_PR);
  wire bus_pc_we = wr_i && (addr_i == `CRS_A_PC);
  wire [31:0] bus_rd_val =
    bus_gp ? gp[bus_gp_idx] :
    (addr_i == `CRS_A_PSW) ? psw :
    (addr_i == `CRS_A_PBASE) ? pbase :
    (addr_i == `CRS_A_VBASE) ? vbase :
    (addr_i == `CRS_A_MACH) ? mach :
    (addr_i == `CRS_A_MACL) ? macl :
    (addr_i == `CRS_A_PR) ? pr :
    (addr_i == `CRS_A_PC) ? pc : `CRS_ZERO;

  // ****************************************
  // core-side selects
  // ****************************************
  wire sys_psw_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_PSW);
  wire sys_pbase_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_PBASE);
  wire sys_vbase_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_VBASE);
  wire sys_mach_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_MACH);
  wire sys_macl_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_MACL);
  wire sys_pr_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_PR);
  wire sys_pc_we = sys_hit(sys_wr_i, sys_wr_sel_i, `CRS_SYS_PC);
  wire [31:0] disp_ext = {24'h000000, disp_i} << disp_sz_i;
  wire [31:0] vec_ofs = {22'h000000, vec_num_i, 2'h0};
  wire [31:0] sp = gp[`CRS_SP_IDX];
  wire [31:0] sp_dec = sp - `CRS_WORD_BYTES;
  wire [31:0] sp_inc = sp + `CRS_WORD_BYTES;

  // ****************************************
  // exception stack sequencer
  // ****************************************
  wire st_idle = (state == crs_pkg::CRS_IDLE);
  wire st_push = (state == crs_pkg::CRS_PUSH_PSW) || (state == crs_pkg::CRS_PUSH_PC);
  wire st_pop = (state == crs_pkg::CRS_POP_PC) || (state == crs_pkg::CRS_POP_PSW);
  wire ld_pc = (state == crs_pkg::CRS_LD_PC);
  wire ld_psw = (state == crs_pkg::CRS_LD_PSW);
  wire [31:0] stk_push_data = (state == crs_pkg::CRS_PUSH_PSW) ? psw : pc;

  always_comb begin
    next_state = state;
    unique case (state)
      crs_pkg::CRS_IDLE: begin
        if (exc_entry_i) begin
          next_state = crs_pkg::CRS_PUSH_PSW;
        end else if (exc_return_i) begin
          next_state = crs_pkg::CRS_POP_PC;
        end
      end
      crs_pkg::CRS_PUSH_PSW: next_state = crs_pkg::CRS_PUSH_PC;
      crs_pkg::CRS_PUSH_PC: next_state = crs_pkg::CRS_IDLE;
      crs_pkg::CRS_POP_PC: next_state = crs_pkg::CRS_POP_PSW;
      crs_pkg::CRS_POP_PSW: next_state = crs_pkg::CRS_LD_PC;
      crs_pkg::CRS_LD_PC: next_state = crs_pkg::CRS_LD_PSW;
      crs_pkg::CRS_LD_PSW: next_state = crs_pkg::CRS_IDLE;
      default: next_state = crs_pkg::CRS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= crs_pkg::CRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // stack strobes lag the sequencer state by one cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stk_we_o <= 1'b0;
      stk_re_o <= 1'b0;
      stk_addr_o <= `CRS_ZERO;
      stk_wdata_o <= `CRS_ZERO;
      stk_busy_o <= 1'b0;
    end else begin
      stk_we_o <= st_push;
      stk_re_o <= st_pop;
      stk_addr_o <= st_push ? sp_dec : sp;
      stk_wdata_o <= stk_push_data;
      stk_busy_o <= (next_state != crs_pkg::CRS_IDLE);
    end
  end

  // ****************************************
  // general registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 16; i++) begin
        gp[i] <= `CRS_ZERO;
      end
    end else begin
      if (bus_gp_we) begin
        gp[bus_gp_idx] <= wdata_i;
      end
      if (gp_wr_i) begin
        gp[gp_wr_sel_i] <= gp_wr_data_i;
      end
      if (st_push) begin
        gp[`CRS_SP_IDX] <= sp_dec;
      end else if (st_pop) begin
        gp[`CRS_SP_IDX] <= sp_inc;
      end
    end
  end

  // ****************************************
  // control and system registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      psw <= `CRS_PSW_RST;
    end else if (ld_psw) begin
      psw <= psw_clean(stk_rdata_i);
    end else begin
      if (sys_psw_we) begin
        psw <= psw_clean(sys_wr_data_i);
      end else if (bus_psw_we) begin
        psw <= psw_clean(wdata_i);
      end
      if (div_we_i) begin
        psw[`CRS_PSW_Q] <= div_q_i;
        psw[`CRS_PSW_M] <= div_m_i;
      end
      if (cond_we_i) begin
        psw[`CRS_PSW_T] <= cond_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pbase <= `CRS_ZERO;
      vbase <= `CRS_VBASE_RST;
      mach <= `CRS_ZERO;
      macl <= `CRS_ZERO;
      pr <= `CRS_ZERO;
    end else begin
      if (sys_pbase_we || bus_pbase_we) begin
        pbase <= sys_pbase_we ? sys_wr_data_i : wdata_i;
      end
      if (sys_vbase_we || bus_vbase_we) begin
        vbase <= sys_vbase_we ? sys_wr_data_i : wdata_i;
      end
      if (sys_mach_we || bus_mach_we) begin
        mach <= sys_mach_we ? sys_wr_data_i : wdata_i;
      end
      if (sys_macl_we || bus_macl_we) begin
        macl <= sys_macl_we ? sys_wr_data_i : wdata_i;
      end
      if (sys_pr_we || bus_pr_we) begin
        pr <= sys_pr_we ? sys_wr_data_i : wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc <= `CRS_ZERO;
    end else if (ld_pc) begin
      pc <= stk_rdata_i;
    end else if (sys_pc_we || bus_pc_we) begin
      pc <= sys_pc_we ? sys_wr_data_i : wdata_i;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= `CRS_ZERO;
      gp_rd_a_o <= `CRS_ZERO;
      gp_rd_b_o <= `CRS_ZERO;
      idx_addr_o <= `CRS_ZERO;
      periph_addr_o <= `CRS_ZERO;
      vec_addr_o <= `CRS_ZERO;
    end else begin
      rdata_o <= rd_i ? bus_rd_val : `CRS_ZERO;
      gp_rd_a_o <= gp[gp_rd_a_sel_i];
      gp_rd_b_o <= gp[gp_rd_b_sel_i];
      idx_addr_o <= gp[`CRS_IDX_IDX] + gp[gp_rd_a_sel_i];
      periph_addr_o <= pbase + disp_ext;
      vec_addr_o <= vbase + vec_ofs;
    end
  end

  assign psw_o = psw;
  assign pc_o = pc;
  assign sp_o = sp;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_psw_reserved_zero: assert property (
    (psw_o & ~`CRS_PSW_WMASK) == `CRS_ZERO)
    else $error("reserved status bits not zero");

  a_mask_reset_ones: assert property (disable iff (1'b0)
    srst_i |=> psw_o[`CRS_PSW_MSK_HI:`CRS_PSW_MSK_LO] == `CRS_MSK_ALL)
    else $error("mask not all ones after reset");

  a_rsv_write_dropped: assert property (
    bus_psw_we && !sys_wr_i && !ld_psw && !cond_we_i && !div_we_i
    |=> psw_o == ($past(wdata_i) & `CRS_PSW_WMASK))
    else $error("status write not masked");

  a_cond_capture: assert property (
    cond_we_i && !ld_psw |=> psw_o[`CRS_PSW_T] == $past(cond_i))
    else $error("condition bit not captured");

  a_div_flags: assert property (
    div_we_i && !ld_psw
    |=> psw_o[`CRS_PSW_Q] == $past(div_q_i) && psw_o[`CRS_PSW_M] == $past(div_m_i))
    else $error("divide flags not captured");

  a_sat_write: assert property (
    sys_psw_we && !ld_psw |=> psw_o[`CRS_PSW_S] == $past(sys_wr_data_i[`CRS_PSW_S]))
    else $error("saturation flag not written");

  a_mask_write: assert property (
    sys_psw_we && !ld_psw
    |=> psw_o[`CRS_PSW_MSK_HI:`CRS_PSW_MSK_LO] ==
        $past(sys_wr_data_i[`CRS_PSW_MSK_HI:`CRS_PSW_MSK_LO]))
    else $error("interrupt mask not written");

  a_gp_write_read: assert property (
    gp_wr_i && !(st_push || st_pop) && gp_wr_sel_i == gp_rd_a_sel_i
    ##1 gp_rd_a_sel_i == $past(gp_wr_sel_i)
    |=> gp_rd_a_o == $past(gp_wr_data_i, 2))
    else $error("general register write lost");

  a_index_addr: assert property (
    1'b1 |=> idx_addr_o == $past(gp[`CRS_IDX_IDX]) + $past(gp[gp_rd_a_sel_i]))
    else $error("index address wrong");

  a_periph_addr: assert property (
    1'b1 |=> periph_addr_o == $past(pbase) + ($past({24'h000000, disp_i}) << $past(disp_sz_i)))
    else $error("peripheral address wrong");

  a_vector_addr: assert property (
    1'b1 |=> vec_addr_o == $past(vbase) + {22'h000000, $past(vec_num_i), 2'h0})
    else $error("vector address wrong");

  a_push_sequence: assert property (
    st_idle && exc_entry_i && !gp_wr_i && !bus_gp_we
    ##1 !gp_wr_i && !bus_gp_we ##1 !gp_wr_i && !bus_gp_we
    |=> stk_we_o && stk_wdata_o == $past(pc, 1) ##0 sp_o == $past(sp_o, 3) - 32'h00000008)
    else $error("exception push sequence wrong");

  a_pop_sequence: assert property (
    st_idle && exc_return_i && !exc_entry_i |=> ##1 stk_re_o [*2] ##1 !stk_re_o)
    else $error("exception pop strobes wrong");

  a_pop_restore: assert property (
    ld_psw |=> psw_o == ($past(stk_rdata_i) & `CRS_PSW_WMASK))
    else $error("status word not restored");

  c_exc_entry: cover property (st_idle && exc_entry_i ##3 !stk_busy_o);
  c_exc_return: cover property (st_idle && exc_return_i ##5 st_idle);
  c_cond_set: cover property (cond_we_i && cond_i);
  c_bus_psw_rw: cover property (bus_psw_we ##1 rd_i && addr_i == `CRS_A_PSW);

endmodule
